/* inc/ebsp_defs.svh */
/*
  timing, slot plan and register map constants for the base-station port.
  assumes inclusion by bare name; 20 MHz system clock.
*/
`ifndef EBSP_DEFS_SVH
`define EBSP_DEFS_SVH
`define EBSP_CLK_HZ          20000000
`define EBSP_BIT_HZ          2048000
`define EBSP_SLOTS           32
`define EBSP_SLOT_SYNC       5'h00
`define EBSP_SLOT_VOICE_LO   5'h01
`define EBSP_SLOT_VOICE_HI   5'h08
`define EBSP_SLOT_SIG        5'h10
`define EBSP_SLOT_PULSE      5'h11
`define EBSP_FAS_WORD        8'h1b
`define EBSP_IDLE_WORD       8'hff
`define EBSP_PULSE_WORD      8'h01
`define EBSP_MF_FRAMES       12'ha00
`define EBSP_OFF_MS          5000
`define EBSP_TRY_MS          200
`define EBSP_REG_CTRL        4'h0
`define EBSP_REG_STAT        4'h4
`define EBSP_REG_SIG_TX      4'h8
`define EBSP_REG_SIG_RX      4'hc
`endif

/* inc/ebsp_pkg.sv */
/*
  types for the base-station port.
  assumes nothing beyond the constants header.
*/
package ebsp_pkg;
  typedef enum logic [1:0] {EBSP_BRK_OFF, EBSP_BRK_ON, EBSP_BRK_WAIT, EBSP_BRK_TRY} ebsp_brk_e;
endpackage : ebsp_pkg

/* design/ebsp_breaker.sv */
/*
  one electronic power breaker with retry cycle.
  assumes short_i is already synchronised; one_ms_i pulses once per ms.
*/
`include "ebsp_defs.svh"
module ebsp_breaker #(
  parameter int OFF_MS = `EBSP_OFF_MS,
  parameter int TRY_MS = `EBSP_TRY_MS
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic enable_i,
  input  wire logic short_i,
  input  wire logic one_ms_i,
  output logic      fet_on_o,
  output logic      short_flag_o
);
  ebsp_pkg::ebsp_brk_e st_r;
  logic [12:0]         ms_r;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= ebsp_pkg::EBSP_BRK_OFF;
      ms_r <= 13'h0000;
    end else if (!enable_i) begin
      st_r <= ebsp_pkg::EBSP_BRK_OFF;
      ms_r <= 13'h0000;
    end else begin
      unique case (st_r)
        ebsp_pkg::EBSP_BRK_OFF: st_r <= ebsp_pkg::EBSP_BRK_ON;
        ebsp_pkg::EBSP_BRK_ON: begin
          if (short_i) begin
            st_r <= ebsp_pkg::EBSP_BRK_WAIT;
            ms_r <= 13'h0000;
          end
        end
        ebsp_pkg::EBSP_BRK_WAIT: begin
          if (one_ms_i) begin
            if (ms_r == 13'(OFF_MS - 1)) begin
              st_r <= ebsp_pkg::EBSP_BRK_TRY;
              ms_r <= 13'h0000;
            end else begin
              ms_r <= ms_r + 13'h0001;
            end
          end
        end
        ebsp_pkg::EBSP_BRK_TRY: begin
          if (short_i) begin
            st_r <= ebsp_pkg::EBSP_BRK_WAIT;
            ms_r <= 13'h0000;
          end else if (one_ms_i) begin
            if (ms_r == 13'(TRY_MS - 1)) begin
              st_r <= ebsp_pkg::EBSP_BRK_ON;
            end else begin
              ms_r <= ms_r + 13'h0001;
            end
          end
        end
      endcase
    end
  end

  assign fet_on_o     = (st_r == ebsp_pkg::EBSP_BRK_ON) || (st_r == ebsp_pkg::EBSP_BRK_TRY);
  assign short_flag_o = (st_r == ebsp_pkg::EBSP_BRK_WAIT);

  fet_off_wait_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (st_r == ebsp_pkg::EBSP_BRK_ON && short_i && enable_i) |=> !fet_on_o)
    else $error("breaker did not drop fet on short");
endmodule : ebsp_breaker

/* design/ebsp_port.sv */
/*
  four-channel E1 base-station port: slot plan framing, 320 ms pulse,
  relays, breakers, Avalon-MM registers.
  assumes pin inputs asynchronous to ref_clk_i; bit clock and frame sync
  arrive as pins and are sampled.
*/
// Implementation choices: the address map and the Avalon-MM register port.
`include "ebsp_defs.svh"
module ebsp_port #(
  parameter int NCH     = 4,
  parameter int OFF_MS  = `EBSP_OFF_MS,
  parameter int TRY_MS  = `EBSP_TRY_MS
) (
  input  wire logic           ref_clk_i,
  input  wire logic           rst_n_i,
  input  wire logic [3:0]     avs_address_i,
  input  wire logic           avs_read_i,
  input  wire logic           avs_write_i,
  input  wire logic [31:0]    avs_writedata_i,
  input  wire logic [3:0]     avs_byteenable_i,
  output logic [31:0]         avs_readdata_o,
  output logic                avs_waitrequest_o,
  input  wire logic           backplane_bit_clock_i,
  input  wire logic           backplane_frame_sync_i,
  input  wire logic [NCH-1:0] matrix_tx_data_i,
  output logic [NCH-1:0]      matrix_rx_data_o,
  input  wire logic [NCH-1:0] line_rx_pair_i,
  output logic [NCH-1:0]      line_tx_pair_o,
  output logic [NCH-1:0]      loop_relay_o,
  output logic [NCH-1:0]      bs_reset_relay_o,
  input  wire logic [NCH-1:0] short_i,
  output logic [NCH-1:0]      fet_on_o,
  output logic                mf_pulse_o
);
  localparam int MS_CYC = `EBSP_CLK_HZ / 1000;

  ////////////////////////////////////////////////////////////////////////////
  // reset and pin synchronisers
  logic [1:0] rst_sync_r;
  logic       rst_n;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) rst_sync_r <= 2'h0;
    else rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  localparam int SW = 2 + 3 * NCH;
  logic [SW-1:0] s1_r, s2_r, s3_r;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= {backplane_bit_clock_i, backplane_frame_sync_i, matrix_tx_data_i,
               line_rx_pair_i, short_i};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  logic           bclk_rise, fs_lvl;
  logic [NCH-1:0] mtx, lrx, shrt;
  assign bclk_rise = s2_r[SW-1] && !s3_r[SW-1];
  assign fs_lvl    = s2_r[SW-2];
  assign mtx       = s2_r[3*NCH-1:2*NCH];
  assign lrx       = s2_r[2*NCH-1:NCH];
  assign shrt      = s2_r[NCH-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // bit and slot counters locked to backplane frame sync
  logic [2:0]  bit_r;
  logic [4:0]  slot_r;
  logic        last_bit;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bit_r  <= 3'h0;
      slot_r <= 5'h00;
    end else if (bclk_rise) begin
      if (fs_lvl) begin
        bit_r  <= 3'h0;
        slot_r <= 5'h00;
      end else begin
        bit_r  <= bit_r + 3'h1;
        if (bit_r == 3'h7) slot_r <= slot_r + 5'h01;
      end
    end
  end
  assign last_bit = bclk_rise && (bit_r == 3'h7) && (slot_r == 5'h1f);

  // multiframe pulse counter
  logic [11:0] fr_r;
  logic        mf_r;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fr_r <= 12'h000;
      mf_r <= 1'b0;
    end else if (last_bit) begin
      if (fr_r == `EBSP_MF_FRAMES - 12'h001) begin
        fr_r <= 12'h000;
        mf_r <= 1'b1;
      end else begin
        fr_r <= fr_r + 12'h001;
        mf_r <= 1'b0;
      end
    end
  end
  assign mf_pulse_o = mf_r;

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [NCH-1:0] loop_r, rst_r, brk_en_r;
  logic [7:0]     sig_tx_r [NCH];
  logic [7:0]     sig_rx_r [NCH];
  logic [NCH-1:0] flag;
  logic           ack_r;
  logic [31:0]    rd_r;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      loop_r   <= '0;
      rst_r    <= '0;
      brk_en_r <= '0;
      for (int c = 0; c < NCH; c++) sig_tx_r[c] <= `EBSP_IDLE_WORD;
    end else if (avs_write_i && ack_r) begin
      if (avs_address_i == `EBSP_REG_CTRL && avs_byteenable_i[0]) begin
        loop_r   <= avs_writedata_i[NCH-1:0];
        rst_r    <= avs_writedata_i[2*NCH-1:NCH];
      end
      if (avs_address_i == `EBSP_REG_CTRL && avs_byteenable_i[1])
        brk_en_r <= avs_writedata_i[8+NCH-1:8];
      if (avs_address_i == `EBSP_REG_SIG_TX)
        for (int c = 0; c < NCH; c++)
          if (avs_byteenable_i[c]) sig_tx_r[c] <= avs_writedata_i[8*c+:8];
    end
  end
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      rd_r  <= 32'h00000000;
    end else begin
      ack_r <= (avs_read_i || avs_write_i) && !ack_r;
      rd_r  <= 32'h00000000;
      if (avs_read_i && !ack_r) begin
        unique case (avs_address_i)
          `EBSP_REG_CTRL: rd_r <= {16'h0000, 4'h0, brk_en_r, rst_r, loop_r};
          `EBSP_REG_STAT: rd_r <= {24'h000000, 4'h0, flag};
          `EBSP_REG_SIG_TX: rd_r <= {sig_tx_r[3], sig_tx_r[2], sig_tx_r[1], sig_tx_r[0]};
          `EBSP_REG_SIG_RX: rd_r <= {sig_rx_r[3], sig_rx_r[2], sig_rx_r[1], sig_rx_r[0]};
          default: rd_r <= 32'h00000000;
        endcase
      end
    end
  end
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;
  assign avs_readdata_o    = rd_r;
  assign loop_relay_o      = loop_r;
  assign bs_reset_relay_o  = rst_r;

  ////////////////////////////////////////////////////////////////////////////
  // per-channel framing and elastic buffers
  logic [7:0] tx_word [NCH];
  logic [7:0] tx_sh_r [NCH];
  logic [7:0] rx_sh_r [NCH];
  logic [7:0] elas_up_r [NCH];
  logic [7:0] elas_dn_r [NCH];
  logic [7:0] up_sh_r [NCH];
  logic [NCH-1:0] ltx_r, mrx_r;
  logic [NCH-1:0] rx_bit;

  // loopback takes the bit being sent now, so words stay slot aligned
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      if (slot_r == `EBSP_SLOT_SYNC)
        tx_word[c] = `EBSP_FAS_WORD;
      else if (slot_r >= `EBSP_SLOT_VOICE_LO && slot_r <= `EBSP_SLOT_VOICE_HI)
        tx_word[c] = elas_dn_r[c];
      else if (slot_r == `EBSP_SLOT_SIG)
        tx_word[c] = sig_tx_r[c];
      else if (slot_r == `EBSP_SLOT_PULSE)
        tx_word[c] = mf_r ? `EBSP_PULSE_WORD : 8'h00;
      else
        tx_word[c] = `EBSP_IDLE_WORD;
      rx_bit[c] = loop_r[c] ? tx_word[c][3'h7 - bit_r] : lrx[c];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < NCH; c++) begin
        tx_sh_r[c]   <= `EBSP_IDLE_WORD;
        rx_sh_r[c]   <= 8'h00;
        elas_up_r[c] <= `EBSP_IDLE_WORD;
        elas_dn_r[c] <= `EBSP_IDLE_WORD;
        up_sh_r[c]   <= `EBSP_IDLE_WORD;
        sig_rx_r[c]  <= 8'h00;
      end
      ltx_r <= '1;
      mrx_r <= '1;
    end else if (bclk_rise) begin
      for (int c = 0; c < NCH; c++) begin
        rx_sh_r[c] <= {rx_sh_r[c][6:0], rx_bit[c]};
        tx_sh_r[c] <= {tx_sh_r[c][6:0], mtx[c]};
        if (bit_r == 3'h7) begin
          elas_dn_r[c] <= {tx_sh_r[c][6:0], mtx[c]};
          if (slot_r >= `EBSP_SLOT_VOICE_LO && slot_r <= `EBSP_SLOT_VOICE_HI)
            elas_up_r[c] <= {rx_sh_r[c][6:0], rx_bit[c]};
          if (slot_r == `EBSP_SLOT_SIG)
            sig_rx_r[c] <= {rx_sh_r[c][6:0], rx_bit[c]};
          up_sh_r[c] <= elas_up_r[c];
        end else begin
          up_sh_r[c] <= {up_sh_r[c][6:0], 1'b1};
        end
        ltx_r[c] <= tx_word[c][3'h7 - bit_r];
        mrx_r[c] <= up_sh_r[c][7];
      end
    end
  end
  assign line_tx_pair_o   = ltx_r;
  assign matrix_rx_data_o = mrx_r;

  ////////////////////////////////////////////////////////////////////////////
  // millisecond enable and breakers
  logic [14:0] ms_cnt_r;
  logic        one_ms;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) ms_cnt_r <= 15'h0000;
    else if (ms_cnt_r == 15'(MS_CYC - 1)) ms_cnt_r <= 15'h0000;
    else ms_cnt_r <= ms_cnt_r + 15'h0001;
  end
  assign one_ms = (ms_cnt_r == 15'(MS_CYC - 1));

  for (genvar g = 0; g < NCH; g++) begin : g_brk
    ebsp_breaker #(.OFF_MS(OFF_MS), .TRY_MS(TRY_MS)) u_brk (
      .ref_clk_i    (ref_clk_i),
      .rst_n_i      (rst_n),
      .enable_i     (brk_en_r[g]),
      .short_i      (shrt[g]),
      .one_ms_i     (one_ms),
      .fet_on_o     (fet_on_o[g]),
      .short_flag_o (flag[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence frame_end_s;
    last_bit;
  endsequence
  mf_period_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (frame_end_s and fr_r == `EBSP_MF_FRAMES - 12'h001) |=> mf_r)
    else $error("pulse not set at multiframe end");
  mf_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (frame_end_s and fr_r != `EBSP_MF_FRAMES - 12'h001) |=> !mf_r)
    else $error("pulse held past its frame");
  slot_sync_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    slot_r == `EBSP_SLOT_SYNC |-> tx_word[0] == `EBSP_FAS_WORD)
    else $error("slot zero not alignment");
  slot_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (slot_r > `EBSP_SLOT_VOICE_HI && slot_r < `EBSP_SLOT_SIG) |-> tx_word[1] == `EBSP_IDLE_WORD)
    else $error("idle slot not idle");
  slot_sig_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    slot_r == `EBSP_SLOT_SIG |-> tx_word[2] == sig_tx_r[2])
    else $error("signaling slot wrong");
  fs_lock_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (bclk_rise && fs_lvl) |=> (slot_r == 5'h00 && bit_r == 3'h0))
    else $error("frame sync did not realign");
  bus_wait_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    ((avs_read_i || avs_write_i) && !ack_r) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("bus answer not one cycle");
  relay_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (avs_write_i && ack_r && avs_address_i == `EBSP_REG_CTRL && avs_byteenable_i[0])
    |=> loop_relay_o == $past(avs_writedata_i[NCH-1:0]))
    else $error("relay bits not written");
endmodule : ebsp_port

/* test/ebsp_station_model.sv */
/*
  remote base station on four E1 links: makes bit clock and frame sync,
  sends a fixed frame on every line, captures each transmitted slot.
  assumes the port samples on bit clock rise and changes after it.
*/
module ebsp_station_model (
  output logic            bit_clk_o,
  output logic            frame_sync_o,
  output logic [3:0]      line_rx_o,
  input  wire logic [3:0] line_tx_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tx_slot [4][32];
  logic [7:0] sh      [4];
  logic [7:0] bit_n;
  logic [7:0] w;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rx_word(input logic [4:0] s);
    if (s == 5'h00) return 8'h1b;
    if (s >= 5'h01 && s <= 5'h08) return 8'h5a;
    if (s == 5'h10) return 8'ha5;
    if (s == 5'h11) return 8'h00;
    return 8'hff;
  endfunction : rx_word

  initial begin
    bit_clk_o = 1'b0;
    frame_sync_o = 1'b0;
    line_rx_o = 4'hf;
    bit_n = 8'hff;
    forever #244 bit_clk_o = ~bit_clk_o;
  end

  // capture finished bit, then present the next one msb first
  always @(negedge bit_clk_o) begin
    for (int c = 0; c < 4; c++) begin
      sh[c] = {sh[c][6:0], line_tx_i[c]};
      if (bit_n[2:0] == 3'h7) tx_slot[c][bit_n[7:3]] = sh[c];
    end
    bit_n = bit_n + 8'h01;
    frame_sync_o = (bit_n == 8'hff);
    w = rx_word(bit_n[7:3]);
    line_rx_o = {4{w[3'h7 - bit_n[2:0]]}};
  end
endmodule : ebsp_station_model

/* test/ebsp_port_test.sv */
/*
  self-checking bench for the base-station port: registers over the bus,
  framing on all lines, loopback, relays and the breaker retry cycle.
  assumes the station model and short breaker times of one ms.
*/
module ebsp_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, rd, wr, bclk, fs, wq, mf;
  logic [3:0]  adr, be, mtx, mrx, lrx, ltx, loop, bsr, shrt, fet;
  logic [31:0] wd, rdat;
  int          err_count, n_tests;

  ebsp_port #(.NCH(4), .OFF_MS(1), .TRY_MS(1)) uut (
    .ref_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .backplane_bit_clock_i(bclk),
    .backplane_frame_sync_i(fs), .matrix_tx_data_i(mtx), .matrix_rx_data_o(mrx),
    .line_rx_pair_i(lrx), .line_tx_pair_o(ltx), .loop_relay_o(loop),
    .bs_reset_relay_o(bsr), .short_i(shrt), .fet_on_o(fet), .mf_pulse_o(mf));

  ebsp_station_model bs (.bit_clk_o(bclk), .frame_sync_o(fs), .line_rx_o(lrx),
    .line_tx_i(ltx));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task wrap_up;
    if (err_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task lim(input int k, input int n);
    if (k >= n) begin
      err_count++;
      wrap_up();
    end
  endtask : lim

  task bus(input logic w, input logic [3:0] a, input logic [31:0] d,
           output logic [31:0] q);
    int k;
    @(posedge clk);
    adr <= a;
    wr  <= w;
    rd  <= !w;
    wd  <= d;
    be  <= 4'hf;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wq !== 1'b0 && k < 100);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    lim(k, 100);
  endtask : bus

  task wr32(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr32

  task rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask : rchk

  task wait_frames(input int n);
    int k, seen;
    logic p;
    k = 0;
    seen = 0;
    p = fs;
    while (seen < n && k < n * 3000) begin
      @(posedge clk);
      k++;
      if (fs && !p) seen++;
      p = fs;
    end
    lim(k, n * 3000);
  endtask : wait_frames

  task wait_fet(input int c, input logic v);
    int k;
    k = 0;
    while (fet[c] !== v && k < 50000) begin
      @(posedge clk);
      k++;
    end
    lim(k, 50000);
  endtask : wait_fet

  function automatic logic [7:0] tx_exp(input int c, input int s);
    if (s == 0) return 8'h1b;
    if (s <= 8) return 8'h00;
    if (s == 16) return 8'(8'h11 * (c + 1));
    if (s == 17) return 8'h00;
    return 8'hff;
  endfunction : tx_exp

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    err_count = 0;
    n_tests = 0;
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 4'h0;
    wd = 32'h0;
    be = 4'h0;
    mtx = 4'h0;
    shrt = 4'h0;
    repeat (5) @(posedge clk);
    chk("idle_tx", {28'h0, ltx}, 32'hf);
    chk("relays_rst", {24'h0, loop, bsr}, 32'h0);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    rchk("ctrl_rst", 4'h0, 32'h0);
    rchk("stat_rst", 4'h4, 32'h0);
    wr32(4'h2, 32'hffff_ffff);
    rchk("unmapped", 4'h2, 32'h0);
    rchk("ctrl_kept", 4'h0, 32'h0);
    wr32(4'h0, 32'h0000_0fa0);
    wr32(4'h8, 32'h4433_2211);
    rchk("ctrl", 4'h0, 32'h0000_0fa0);
    chk("relays", {24'h0, loop, bsr}, 32'h0a);
    wait_fet(0, 1'b1);
    chk("fet_en", {28'h0, fet}, 32'hf);
    wait_frames(3);
    for (int c = 0; c < 4; c++)
      for (int s = 0; s < 32; s++)
        chk("tx_slot", {24'h0, bs.tx_slot[c][s]}, {24'h0, tx_exp(c, s)});
    chk("mf_pulse", {31'h0, mf}, 32'h0);
    rchk("sig_rx", 4'hc, 32'ha5a5_a5a5);
    wr32(4'h0, 32'h0000_0fa1);
    @(posedge clk);
    chk("loop_relay", {28'h0, loop}, 32'h1);
    wait_frames(3);
    rchk("sig_rx_loop", 4'hc, 32'ha5a5_a511);
    wr32(4'h0, 32'h0000_0fa0);
    shrt <= 4'h2;
    wait_fet(1, 1'b0);
    chk("fet_short", {28'h0, fet}, 32'hd);
    rchk("stat_short", 4'h4, 32'h2);
    wait_fet(1, 1'b1);
    wait_fet(1, 1'b0);
    chk("fet_retry", {28'h0, fet}, 32'hd);
    shrt <= 4'h0;
    wait_fet(1, 1'b1);
    repeat (30000) @(posedge clk);
    chk("fet_kept", {28'h0, fet}, 32'hf);
    rchk("stat_clear", 4'h4, 32'h0);
    wr32(4'h0, 32'h0);
    wait_fet(2, 1'b0);
    chk("fet_dis", {24'h0, fet, loop}, 32'h0);
    wrap_up();
  end
endmodule : ebsp_port_test
